/* File: rtl/hwsc_regs.svh */
`ifndef HWSC_REGS_SVH
`define HWSC_REGS_SVH

// Register byte offsets on the AHB-Lite slave
`define HWSC_OFS_CTRL     8'h00
`define HWSC_OFS_WINDOW   8'h04
`define HWSC_OFS_WDSTAT   8'h08
`define HWSC_OFS_IRQ_ST   8'h0c
`define HWSC_OFS_IRQ_MASK 8'h10

// Reset values
`define HWSC_RST_ADDR     8'h01
`define HWSC_RST_WIN      8'h00
`define HWSC_RST_TENTHS   8'h00

// Field positions
`define HWSC_ST_EN_BIT    7
`define HWSC_ST_TO_BIT    2
`define HWSC_WIN_OPEN_BIT 8
`define HWSC_WIN_ALLOW_BIT 9
`define HWSC_IRQ_WDTO     0
`define HWSC_IRQ_BAD      1
`define HWSC_IRQ_HOK      2
`define HWSC_IRQ_W        3

// Limits and frame sizes
`define HWSC_WIN_MAX      8'h3c
`define HWSC_BUF_LEN      6
`define HWSC_LEN_SHORT    3'h4
`define HWSC_LEN_STATUS   3'h6

// Timing: period and units in ns, counts derived from them
`define HWSC_CLK_NS       20
`define HWSC_SEC_NS       1000000000
`define HWSC_TENTH_NS     100000000
`define HWSC_SEC_CYC      (`HWSC_SEC_NS / `HWSC_CLK_NS)
`define HWSC_TENTH_CYC    (`HWSC_TENTH_NS / `HWSC_CLK_NS)

// Frame characters
`define HWSC_CH_TILDE     8'h7e
`define HWSC_CH_BANG      8'h21
`define HWSC_CH_QUES      8'h3f
`define HWSC_CH_CR        8'h0d
`define HWSC_CH_STAR      8'h2a
`define HWSC_CH_T         8'h54
`define HWSC_CH_0         8'h30
`define HWSC_CH_1         8'h31
`define HWSC_CH_3         8'h33

`endif

/* File: rtl/hwsc_pkg.sv */
package hwsc_pkg;
    // Receive framer states
    typedef enum logic [1:0] {
        HWSC_RX_IDLE,
        HWSC_RX_BODY,
        HWSC_RX_DROP
    } hwsc_rx_t;
    typedef logic [7:0] hwsc_byte_t;
endpackage

/* File: rtl/hwsc_tick.sv */
`timescale 1ns/100ps
`default_nettype none
module hwsc_tick
    import hwsc_pkg::*;
#(
    parameter int unsigned CYC = 50
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Restart and tick
    input  wire logic restart,
    output logic      tick
);
    localparam int unsigned W = $clog2(CYC + 1);
    localparam logic [W-1:0] LAST = W'(CYC - 1);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    // Restart realigns the period so the first interval is whole
    assign tick    = (cnt_r == LAST) && !restart;
    assign cnt_nxt = (restart || tick) ? '0 : cnt_r + W'(1);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule // hwsc_tick
`default_nettype wire

/* File: rtl/hwsc_nvstat.sv */
`timescale 1ns/100ps
`default_nettype none
`include "hwsc_regs.svh"
module hwsc_nvstat
    import hwsc_pkg::*;
(
    // Clock and storage reset (first programming only)
    input  wire logic       core_clk,
    input  wire logic       nv_rst,
    // Update strobes
    input  wire logic       cfg_we,
    input  wire logic       cfg_en,
    input  wire hwsc_byte_t cfg_tenths,
    input  wire logic       to_set,
    input  wire logic       to_clr,
    // Stored state
    output logic            wd_en_r,
    output logic            wd_to_r,
    output hwsc_byte_t      wd_tenths_r
);
    // Kept apart from the logic reset so it outlives a power cycle
    always_ff @(posedge core_clk or posedge nv_rst) begin
        if (nv_rst) begin
            wd_en_r     <= 1'b0;
            wd_to_r     <= 1'b0;
            wd_tenths_r <= `HWSC_RST_TENTHS;
        end else begin
            if (cfg_we) begin
                wd_en_r     <= cfg_en;
                wd_tenths_r <= cfg_tenths;
            end
            if (to_clr) begin
                wd_to_r <= 1'b0;
            end
            if (to_set) begin
                wd_to_r <= 1'b1;
                wd_en_r <= 1'b0;
            end
        end
    end
endmodule // hwsc_nvstat
`default_nettype wire

/* File: rtl/hwsc_top.sv */
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "hwsc_regs.svh"
// How it works
// - Bad syntax, receive error or foreign address gives no reply at all.
// - Address is two hex characters, 00 to FF; replies echo our address.
// - Set-window command answers '!' plus address, or '?' when rejected.
// - Set-window frame is tilde, address, T, two hex seconds digits.
// - Window timeout above sixty seconds is rejected and not stored.
// - Zero window keeps software-only settings changes refused.
// - Window timeout is zero after power-on reset.
// - Tilde-star-star host-alive is taken by all modules, never answered.
// - Command 0 replies '!', address and two hex status digits.
// - Status bit 7 shows watchdog enabled.
// - Status bit 2 shows a watchdog timeout occurred.
// - Status survives power cycles; only the clear command resets timeout.
// - Command 1 clears the timeout flag and replies '!' plus address.
// - Configure carries enable digit and two hex digits in tenths.
// - Watchdog timeout disables the watchdog until reconfigured.
module hwsc_top
    import hwsc_pkg::*;
#(
    parameter int unsigned SEC_CYC   = `HWSC_SEC_CYC,
    parameter int unsigned TENTH_CYC = `HWSC_TENTH_CYC
) (
    // Clock and resets
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        nv_rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Received characters
    input  wire hwsc_byte_t  rx_data,
    input  wire logic        rx_valid,
    input  wire logic        rx_err,
    output logic             rx_ready,
    // Reply characters
    output hwsc_byte_t       tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    // Links to the rest of the module
    input  wire logic        init_strap_n,
    input  wire logic        cfg_unlock_evt,
    output logic             cfg_window_open,
    output logic             cfg_change_allowed,
    output logic             wd_timeout_evt,
    output logic             irq
);
    // Hex helpers: decode gives {valid, nibble}, encode gives upper case
    function automatic logic [4:0] hex_dec(input hwsc_byte_t c);
        logic [4:0] r;
        r = 5'h00;
        if (c >= 8'h30 && c <= 8'h39) r = {1'b1, 4'(c - 8'h30)};
        else if (c >= 8'h41 && c <= 8'h46) r = {1'b1, 4'(c - 8'h37)};
        else if (c >= 8'h61 && c <= 8'h66) r = {1'b1, 4'(c - 8'h57)};
        return r;
    endfunction
    function automatic hwsc_byte_t hex_chr(input logic [3:0] n);
        return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction

    hwsc_rx_t   rx_st_r;
    hwsc_byte_t buf_r [`HWSC_BUF_LEN];
    logic [2:0] cnt_r;
    hwsc_byte_t mod_addr_r, win_to_r, win_cnt_r, wd_cnt_r;
    hwsc_byte_t rep_addr_r, rep_st_r, tx_data_r;
    logic [2:0] rep_len_r, rep_idx_r;
    logic       rep_bad_r, tx_valid_r, wd_evt_r;
    logic [`HWSC_IRQ_W-1:0] irq_st_r, irq_mask_r, irq_ev;
    logic       ap_we_r;
    logic [7:0] ap_ofs_r;
    logic [31:0] hrdata_r, rd_word;
    logic       wd_en, wd_to;
    hwsc_byte_t wd_tenths;
    logic       sec_tick, tenth_tick;

    // Receive framing: '~' opens, CR closes, overrun or error drops
    wire rx_take   = rx_valid && rx_ready;
    wire is_cr     = rx_data == `HWSC_CH_CR;
    wire frame_end = rx_take && !rx_err && is_cr && rx_st_r == HWSC_RX_BODY;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_st_r <= HWSC_RX_IDLE;
            cnt_r   <= 3'h0;
        end else if (rx_take) begin
            case (rx_st_r)
                HWSC_RX_IDLE: begin
                    cnt_r <= 3'h0;
                    if (!rx_err && rx_data == `HWSC_CH_TILDE) rx_st_r <= HWSC_RX_BODY;
                end
                HWSC_RX_BODY: begin
                    if (is_cr) rx_st_r <= HWSC_RX_IDLE;
                    else if (rx_err || cnt_r == 3'(`HWSC_BUF_LEN)) rx_st_r <= HWSC_RX_DROP;
                    else cnt_r <= cnt_r + 3'h1;
                end
                HWSC_RX_DROP: begin
                    if (is_cr) rx_st_r <= HWSC_RX_IDLE;
                end
                default: rx_st_r <= HWSC_RX_IDLE;
            endcase
        end
    end

    // Character store, written only in the body of a frame
    always_ff @(posedge core_clk) begin
        if (rx_take && rx_st_r == HWSC_RX_BODY && !is_cr && cnt_r < 3'(`HWSC_BUF_LEN)) begin
            buf_r[cnt_r] <= rx_data;
        end
    end

    wire [4:0] a_hi = hex_dec(buf_r[0]);
    wire [4:0] a_lo = hex_dec(buf_r[1]);
    wire [4:0] h3   = hex_dec(buf_r[3]);
    wire [4:0] h4   = hex_dec(buf_r[4]);
    wire [4:0] h5   = hex_dec(buf_r[5]);
    wire addr_ok    = a_hi[4] && a_lo[4] && {a_hi[3:0], a_lo[3:0]} == mod_addr_r;
    wire is_hok     = cnt_r == 3'h2 && buf_r[0] == `HWSC_CH_STAR && buf_r[1] == `HWSC_CH_STAR;
    wire is_setwin  = addr_ok && cnt_r == 3'h5 && buf_r[2] == `HWSC_CH_T && h3[4] && h4[4];
    wire [7:0] win_val = {h3[3:0], h4[3:0]};
    wire win_bad    = win_val > `HWSC_WIN_MAX;
    wire is_rdst    = addr_ok && cnt_r == 3'h3 && buf_r[2] == `HWSC_CH_0;
    wire is_clr     = addr_ok && cnt_r == 3'h3 && buf_r[2] == `HWSC_CH_1;
    wire e_ok       = buf_r[3] == `HWSC_CH_0 || buf_r[3] == `HWSC_CH_1;
    wire is_cfg     = addr_ok && cnt_r == 3'h6 && buf_r[2] == `HWSC_CH_3 && e_ok && h4[4] && h5[4];
    wire reply_go   = frame_end && (is_setwin || is_rdst || is_clr || is_cfg);
    wire setwin_ok  = frame_end && is_setwin && !win_bad;
    wire hok_go     = frame_end && is_hok;
    wire cfg_go     = frame_end && is_cfg;
    wire clr_go     = frame_end && is_clr;

    wire [7:0] wd_status = (8'(wd_en) << `HWSC_ST_EN_BIT) | (8'(wd_to) << `HWSC_ST_TO_BIT);

    // Reply sequencer: delimiter, address, optional status, CR
    wire busy    = rep_idx_r != rep_len_r;
    wire advance = busy && (!tx_valid_r || tx_ready);
    wire [2:0] last_idx = rep_len_r - 3'h1;
    wire hwsc_byte_t rep_chr =
        (rep_idx_r == 3'h0)     ? (rep_bad_r ? `HWSC_CH_QUES : `HWSC_CH_BANG) :
        (rep_idx_r == 3'h1)     ? hex_chr(rep_addr_r[7:4]) :
        (rep_idx_r == 3'h2)     ? hex_chr(rep_addr_r[3:0]) :
        (rep_idx_r == last_idx) ? `HWSC_CH_CR :
        (rep_idx_r == 3'h3)     ? hex_chr(rep_st_r[7:4]) : hex_chr(rep_st_r[3:0]);

    // No new frame until the previous reply has fully left
    assign rx_ready = !busy && !tx_valid_r;
    assign tx_data  = tx_data_r;
    assign tx_valid = tx_valid_r;

    // delimiter chosen at decode, status length
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rep_len_r  <= 3'h0;
            rep_idx_r  <= 3'h0;
            rep_bad_r  <= 1'b0;
            rep_addr_r <= 8'h00;
            rep_st_r   <= 8'h00;
        end else if (reply_go) begin
            rep_len_r  <= is_rdst ? `HWSC_LEN_STATUS : `HWSC_LEN_SHORT;
            rep_idx_r  <= 3'h0;
            rep_bad_r  <= is_setwin && win_bad;
            rep_addr_r <= mod_addr_r;
            rep_st_r   <= wd_status;
        end else if (advance) begin
            rep_idx_r <= rep_idx_r + 3'h1;
        end
    end

    // Transmit holding register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_valid_r <= 1'b0;
            tx_data_r  <= 8'h00;
        end else if (advance) begin
            tx_valid_r <= 1'b1;
            tx_data_r  <= rep_chr;
        end else if (tx_ready) begin
            tx_valid_r <= 1'b0;
        end
    end

    // one-second base, realigned when the window opens
    hwsc_tick #(.CYC(SEC_CYC)) u_sec (
        .core_clk (core_clk),
        .rst      (rst),
        .restart  (cfg_unlock_evt),
        .tick     (sec_tick)
    );

    // zero after reset, unlock opens window
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            win_to_r  <= `HWSC_RST_WIN;
            win_cnt_r <= 8'h00;
        end else begin
            if (setwin_ok) win_to_r <= win_val;
            if (setwin_ok && win_val == 8'h00) win_cnt_r <= 8'h00;
            else if (cfg_unlock_evt) win_cnt_r <= win_to_r;
            else if (sec_tick && win_cnt_r != 8'h00) win_cnt_r <= win_cnt_r - 8'h01;
        end
    end

    // software-only change needs an open window
    assign cfg_window_open    = win_cnt_r != 8'h00;
    assign cfg_change_allowed = !init_strap_n || cfg_window_open;

    // host-alive or enabling configure restarts countdown
    wire wd_kick   = hok_go || (cfg_go && buf_r[3] == `HWSC_CH_1);
    wire wd_expire = wd_en && tenth_tick && wd_cnt_r == 8'h01 && !wd_kick;

    hwsc_tick #(.CYC(TENTH_CYC)) u_tenth (
        .core_clk (core_clk),
        .rst      (rst),
        .restart  (wd_kick),
        .tick     (tenth_tick)
    );

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wd_cnt_r <= 8'h00;
            wd_evt_r <= 1'b0;
        end else begin
            wd_evt_r <= wd_expire;
            if (wd_kick) wd_cnt_r <= cfg_go ? {h4[3:0], h5[3:0]} : wd_tenths;
            else if (wd_en && tenth_tick && wd_cnt_r != 8'h00) wd_cnt_r <= wd_cnt_r - 8'h01;
        end
    end
    assign wd_timeout_evt = wd_evt_r;

    hwsc_nvstat u_nv (
        .core_clk    (core_clk),
        .nv_rst      (nv_rst),
        .cfg_we      (cfg_go),
        .cfg_en      (buf_r[3] == `HWSC_CH_1),
        .cfg_tenths  ({h4[3:0], h5[3:0]}),
        .to_set      (wd_expire),
        .to_clr      (clr_go),
        .wd_en_r     (wd_en),
        .wd_to_r     (wd_to),
        .wd_tenths_r (wd_tenths)
    );

    // AHB-Lite decode: zero wait states, always OKAY
    wire ahb_take = hsel && htrans[1] && hready;
    wire wr_ctrl  = ap_we_r && ap_ofs_r == `HWSC_OFS_CTRL;
    wire wr_irqst = ap_we_r && ap_ofs_r == `HWSC_OFS_IRQ_ST;
    wire wr_mask  = ap_we_r && ap_ofs_r == `HWSC_OFS_IRQ_MASK;
    wire [7:0] rd_ofs = haddr[7:0];
    assign rd_word =
        (rd_ofs == `HWSC_OFS_CTRL)     ? {24'h000000, mod_addr_r} :
        (rd_ofs == `HWSC_OFS_WINDOW)   ? {22'h000000, cfg_change_allowed, cfg_window_open, win_to_r} :
        (rd_ofs == `HWSC_OFS_WDSTAT)   ? {24'h000000, wd_status} :
        (rd_ofs == `HWSC_OFS_IRQ_ST)   ? {29'h00000000, irq_st_r} :
        (rd_ofs == `HWSC_OFS_IRQ_MASK) ? {29'h00000000, irq_mask_r} : 32'h00000000;
    assign hrdata    = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Address phase capture; read data staged for the data phase
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ap_we_r  <= 1'b0;
            ap_ofs_r <= 8'h00;
            hrdata_r <= 32'h00000000;
        end else begin
            ap_we_r  <= ahb_take && hwrite;
            ap_ofs_r <= haddr[7:0];
            if (ahb_take && !hwrite) hrdata_r <= rd_word;
        end
    end

    // Event flags: a new event beats a same-cycle write-one clear
    assign irq_ev = {hok_go, reply_go && is_setwin && win_bad, wd_expire};
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mod_addr_r <= `HWSC_RST_ADDR;
            irq_st_r   <= '0;
            irq_mask_r <= '0;
        end else begin
            if (wr_ctrl) mod_addr_r <= hwdata[7:0];
            if (wr_mask) irq_mask_r <= hwdata[`HWSC_IRQ_W-1:0];
            irq_st_r <= (irq_st_r & ~(wr_irqst ? hwdata[`HWSC_IRQ_W-1:0] : '0)) | irq_ev;
        end
    end
    assign irq = |(irq_st_r & irq_mask_r);

    AST_SILENT_FOREIGN:
    assert property (@(posedge core_clk) disable iff (rst) frame_end && !addr_ok && !is_hok |=> !busy)
    else $error("reply started for a foreign or malformed frame");
    AST_ECHO_ADDR:
    assert property (@(posedge core_clk) disable iff (rst) reply_go |=> rep_addr_r == $past(mod_addr_r))
    else $error("reply address differs from module address");
    AST_REJECT_DELIM:
    assert property (@(posedge core_clk) disable iff (rst)
        reply_go && is_setwin && win_bad |=> ##1 (tx_valid_r && tx_data_r == `HWSC_CH_QUES))
    else $error("rejected window command did not lead with question mark");
    AST_WIN_LIMIT:
    assert property (@(posedge core_clk) disable iff (rst) win_to_r <= `HWSC_WIN_MAX)
    else $error("window timeout above sixty seconds stored");
    AST_WIN_ZERO:
    assert property (@(posedge core_clk) disable iff (rst)
        cfg_unlock_evt && win_to_r == 8'h00 && !setwin_ok |=> !cfg_window_open)
    else $error("window opened with zero timeout");
    AST_WIN_CAUSE:
    assert property (@(posedge core_clk) disable iff (rst) win_to_r != $past(win_to_r) |-> $past(setwin_ok))
    else $error("window timeout changed without an accepted command");
    AST_HOK_QUIET:
    assert property (@(posedge core_clk) disable iff (rst) hok_go |=> !busy [*2])
    else $error("host-alive frame produced a reply");
    AST_STATUS_LEN:
    assert property (@(posedge core_clk) disable iff (rst)
        reply_go && is_rdst |=> rep_len_r == `HWSC_LEN_STATUS && rep_st_r == $past(wd_status))
    else $error("status reply malformed");
    AST_TO_DISABLE:
    assert property (@(posedge core_clk) disable iff (rst) wd_expire |=> !wd_en && wd_to && wd_timeout_evt)
    else $error("watchdog expiry did not set flag and disable");
    AST_WIN_CLOSE:
    assert property (@(posedge core_clk) disable iff (rst)
        sec_tick && win_cnt_r == 8'h01 && !cfg_unlock_evt && !setwin_ok |=> !cfg_window_open)
    else $error("window stayed open past its last second");
endmodule // hwsc_top
`default_nettype wire

/* File: test/hwsc_host.sv */
`timescale 1ns/100ps
`default_nettype none
// Host side of the serial link: sends frames, gathers replies
module hwsc_host
    import hwsc_pkg::*;
(
    // Clock
    input  wire logic       core_clk,
    // Characters to the device
    output hwsc_byte_t      rx_data,
    output logic            rx_valid,
    output logic            rx_err,
    input  wire logic       rx_ready,
    // Replies from the device
    input  wire hwsc_byte_t tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready
);
    string reply   = "";
    bit    cr_seen = 1'b0;
    bit    slow    = 1'b0;

    // Idle link at time zero
    initial begin
        rx_data  = 8'h00;
        rx_valid = 1'b0;
        rx_err   = 1'b0;
        tx_ready = 1'b1;
    end

    // tilde, two hex address chars, body, CR
    task automatic send(input string s, input bit err);
        hwsc_byte_t c;
        bit         ok;
        @(posedge core_clk);
        for (int i = 0; i <= s.len() + 1; i++) begin
            c = (i == 0) ? 8'h7e : (i > s.len()) ? 8'h0d : hwsc_byte_t'(s[i-1]);
            rx_data  <= c;
            rx_valid <= 1'b1;
            rx_err   <= err && (i == s.len());
            // Held until taken; ready looked at just before the edge
            do begin
                @(negedge core_clk);
                ok = rx_ready;
                @(posedge core_clk);
            end while (!ok);
        end
        rx_valid <= 1'b0;
        rx_err   <= 1'b0;
        rx_data  <= ~c; // Released line does not keep the last char
    endtask

    // Reply gathering; slow mode stalls every other cycle
    always @(posedge core_clk) begin
        if (tx_valid && tx_ready) begin
            if (tx_data == 8'h0d) cr_seen = 1'b1;
            else reply = $sformatf("%s%c", reply, tx_data);
        end
        tx_ready <= slow ? !tx_ready : 1'b1;
    end
endmodule // hwsc_host
`default_nettype wire

/* File: test/hwsc_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module hwsc_top_tb
    import hwsc_pkg::*;
;
    typedef struct { string cmd; string rep; } hwsc_row_t;
    logic core_clk = 1'b0, rst = 1'b1, nv_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
    logic [1:0] htrans = 2'b00;
    logic hreadyout, hresp, rx_valid, rx_err, rx_ready, tx_valid, tx_ready, irq;
    logic init_strap_n = 1'b1, cfg_unlock_evt = 1'b0, cfg_window_open, cfg_change_allowed, wd_timeout_evt;
    hwsc_byte_t rx_data, tx_data;
    int miscompares = 0, n_tests = 0, to_cnt = 0;
    hwsc_row_t rows [13] = '{'{"01T10", "!01"}, '{"01T3c", "!01"}, '{"01T3D", "?01"}, '{"02T10", ""},
        '{"01X", ""}, '{"01T1", ""}, '{"**", ""}, '{"010", "!0100"}, '{"011", "!01"},
        '{"013100", "!01"}, '{"010", "!0180"}, '{"013000", "!01"}, '{"0130000", ""}};

    // 50 MHz clock
    always #10 core_clk = ~core_clk;
    // Timeout pulses seen
    always @(posedge core_clk) if (wd_timeout_evt === 1'b1) to_cnt++;

    hwsc_top #(.SEC_CYC(20), .TENTH_CYC(4)) DUT (
        .core_clk(core_clk), .rst(rst), .nv_rst(nv_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rx_data(rx_data), .rx_valid(rx_valid), .rx_err(rx_err),
        .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .init_strap_n(init_strap_n), .cfg_unlock_evt(cfg_unlock_evt), .cfg_window_open(cfg_window_open),
        .cfg_change_allowed(cfg_change_allowed), .wd_timeout_evt(wd_timeout_evt), .irq(irq));
    hwsc_host host (.core_clk(core_clk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_err(rx_err),
        .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_str(input string got, input string exp);
        n_tests++;
        if (got != exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Single word transfer; waits on hready in both phases
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk_val(q, exp);
        chk_val(hresp, 32'h0);
    endtask
    // Silent frames wait out the bound, answered ones stop at CR
    task automatic frame(input string s, input bit err, input string exp);
        int n;
        host.reply   = "";
        host.cr_seen = 1'b0;
        host.send(s, err);
        n = 0;
        while (!host.cr_seen && n < 40) begin
            @(posedge core_clk);
            n++;
        end
        chk_str(host.reply, exp);
        $display("test %s done", s);
    endtask
    task automatic pulse_unlock();
        @(posedge core_clk) cfg_unlock_evt <= 1'b1;
        @(posedge core_clk) cfg_unlock_evt <= 1'b0;
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog: the run needs well under 3000 cycles
    initial begin
        repeat (6000) @(posedge core_clk);
        miscompares++;
        finish_test();
    end

    initial begin
        repeat (3) @(posedge core_clk);
        rst    <= 1'b0;
        nv_rst <= 1'b0;
        rd(8'h04, 32'h0);
        rd(8'h00, 32'h1);
        rd(8'h14, 32'h0);
        ahb(1'b1, 8'h10, 32'h1);
        foreach (rows[i]) frame(rows[i].cmd, 1'b0, rows[i].rep);
        rd(8'h04, 32'h3c);
        rd(8'h0c, 32'h6);
        frame("010", 1'b1, "");
        host.slow = 1'b1;
        ahb(1'b1, 8'h00, 32'hff);
        frame("FF0", 1'b0, "!FF00");
        frame("01T00", 1'b0, "");
        ahb(1'b1, 8'h00, 32'h01);
        host.slow = 1'b0;
        frame("01T00", 1'b0, "!01");
        pulse_unlock();
        @(negedge core_clk) chk_val(cfg_window_open, 1'b0);
        chk_val(cfg_change_allowed, 1'b0);
        @(posedge core_clk) init_strap_n <= 1'b0;
        @(negedge core_clk) chk_val(cfg_change_allowed, 1'b1);
        @(posedge core_clk) init_strap_n <= 1'b1;
        frame("01T02", 1'b0, "!01");
        pulse_unlock();
        repeat (30) @(posedge core_clk);
        @(negedge core_clk) chk_val(cfg_window_open, 1'b1);
        chk_val(cfg_change_allowed, 1'b1);
        repeat (20) @(posedge core_clk);
        @(negedge core_clk) chk_val(cfg_window_open, 1'b0);
        frame("01310A", 1'b0, "!01");
        frame("010", 1'b0, "!0180");
        repeat (4) begin
            host.send("**", 1'b0);
            repeat (6) @(posedge core_clk);
        end
        chk_val(to_cnt, 0);
        repeat (50) @(posedge core_clk);
        chk_val(to_cnt, 1);
        chk_val(irq, 1'b1);
        frame("010", 1'b0, "!0104");
        rd(8'h08, 32'h4);
        ahb(1'b1, 8'h0c, 32'h1);
        @(negedge core_clk) chk_val(irq, 1'b0);
        @(posedge core_clk) rst <= 1'b1;
        @(posedge core_clk) rst <= 1'b0;
        rd(8'h04, 32'h0);
        frame("010", 1'b0, "!0104");
        frame("011", 1'b0, "!01");
        frame("010", 1'b0, "!0100");
        finish_test();
    end
endmodule // hwsc_top_tb
`default_nettype wire
